/* File: dual_timer_counter.sv */
// Two timer/counters with mode, control, counting registers and overflow interrupt.
// Assumes a classic Wishbone master on clk_i; count and gate pins are asynchronous.
// Behaviour
// - two independent 16-bit timer/counters, each a timer or an event counter
// - timer operation increments once every 12 clock periods
// - counter operation increments on a falling input edge, detected over two machine cycles
// - run bits at control bit 6 (timer 1) and bit 4 (timer 0) start timers
// - gate enable makes counting need the external interrupt input high too
// - counter-select one counts events, zero counts machine cycles
// - two-bit mode field selects modes 0 to 3 per timer
// - mode 0 is 13 bits; low byte's upper three bits held zero
// - mode 2 increments low byte, reloads it from high byte on overflow
// - timer 1 in mode 3 stops counting
// - timer 0 in mode 3 splits into two independent 8-bit counters
// - split low byte uses timer 0 controls; high byte uses timer 1 run and flag
// - overflow sets flag; software or interrupt acknowledge clears it
// - cleared run bit halts the timer, which holds its value
`include "dual_timer_params.svh"
module dual_timer_counter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic count_input_zero_i,
    input wire logic count_input_one_i,
    input wire logic ext_irq_input_zero_i,
    input wire logic ext_irq_input_one_i,
    input wire logic [1:0] irq_ack_i,
    output logic irq_o
);
    logic [7:0] mode_reg;
    logic [7:0] ctrl_reg;
    logic [7:0] tl0_reg;
    logic [7:0] th0_reg;
    logic [7:0] tl1_reg;
    logic [7:0] th1_reg;
    logic [1:0] stat_reg;
    logic [1:0] mask_reg;
    logic [3:0] pre_reg;
    logic mcycle_reg;
    logic fall0;
    logic fall1;
    logic gate0;
    logic gate1;

    // Machine-cycle prescaler: one strobe every 12 clocks
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pre_reg <= 4'h0;
            mcycle_reg <= 1'b0;
        end else begin
            pre_reg <= (pre_reg == 4'(`TMR_CLK_PER_MCYCLE - 1)) ? 4'h0 : pre_reg + 4'h1;
            mcycle_reg <= (pre_reg == 4'(`TMR_CLK_PER_MCYCLE - 1));
        end
    end

    timer_input_sampler u_in0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mcycle_i(mcycle_reg),
        .count_pin_i(count_input_zero_i),
        .gate_pin_i(ext_irq_input_zero_i),
        .fall_o(fall0),
        .gate_o(gate0)
    );

    timer_input_sampler u_in1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mcycle_i(mcycle_reg),
        .count_pin_i(count_input_one_i),
        .gate_pin_i(ext_irq_input_one_i),
        .fall_o(fall1),
        .gate_o(gate1)
    );

    // Mode decode per timer
    dual_timer_pkg::timer_mode_t mode0;
    dual_timer_pkg::timer_mode_t mode1;
    assign mode0 = dual_timer_pkg::timer_mode_t'(mode_reg[`TMR_BIT_MODE0_HI:`TMR_BIT_MODE0_LO]);
    assign mode1 = dual_timer_pkg::timer_mode_t'(mode_reg[`TMR_BIT_MODE1_HI:`TMR_BIT_MODE1_LO]);

    // Run qualification: run bit, optional gate, tick source
    wire run0 = ctrl_reg[`TMR_BIT_RUN0] & (~mode_reg[`TMR_BIT_GATE0] | gate0);
    wire run1 = ctrl_reg[`TMR_BIT_RUN1] & (~mode_reg[`TMR_BIT_GATE1] | gate1);
    wire tick0 = mode_reg[`TMR_BIT_CT0] ? fall0 : mcycle_reg;
    wire tick1 = mode_reg[`TMR_BIT_CT1] ? fall1 : mcycle_reg;
    wire inc0 = run0 & tick0;
    // In split mode timer 0's high byte borrows timer 1's run bit, machine-cycle clocked
    wire inc0h = ctrl_reg[`TMR_BIT_RUN1] & mcycle_reg;
    wire inc1 = run1 & tick1 & (mode1 != dual_timer_pkg::MODE_SPLIT);

    // Next-state function shared by both timers
    function automatic logic [16:0] step(input logic [1:0] m, input logic [7:0] lo, input logic [7:0] hi);
        logic [8:0] l;
        logic [8:0] h;
        l = 9'h000;
        h = 9'h000;
        step = 17'h00000;
        unique case (m)
            2'b00: begin
                l = {4'h0, lo[4:0]} + 9'h001;
                h = {1'b0, hi} + {8'h00, l[5]};
                step = {h[8], h[7:0], 3'b000, l[4:0]}; // Wraps to zero
            end
            2'b01: begin
                l = {1'b0, lo} + 9'h001;
                h = {1'b0, hi} + {8'h00, l[8]};
                step = {h[8], h[7:0], l[7:0]};
            end
            2'b10: begin
                l = {1'b0, lo} + 9'h001;
                step = {l[8], hi, l[8] ? hi : l[7:0]};
            end
            2'b11: begin
                l = {1'b0, lo} + 9'h001; // Low-byte half of split mode
                step = {l[8], hi, l[7:0]};
            end
        endcase
    endfunction

    wire [16:0] nx0 = step(mode_reg[1:0], tl0_reg, th0_reg);
    wire [16:0] nx1 = step(mode_reg[5:4], tl1_reg, th1_reg);
    wire [8:0] nx0h = {1'b0, th0_reg} + 9'h001;
    wire split0 = (mode0 == dual_timer_pkg::MODE_SPLIT);
    wire ovf0 = inc0 & nx0[16];
    wire ovf1 = split0 ? (inc0h & nx0h[8]) : (inc1 & nx1[16]);

    // Bus decode
    wire req = cyc_i & stb_i & ~ack_o;
    wire wr = req & we_i & sel_i[0];
    wire [3:0] idx = adr_i[5:2];
    wire wr_mode = wr & (idx == `TMR_OFS_MODE);
    wire wr_ctrl = wr & (idx == `TMR_OFS_CTRL);
    wire wr_tl0 = wr & (idx == `TMR_OFS_TL0);
    wire wr_th0 = wr & (idx == `TMR_OFS_TH0);
    wire wr_tl1 = wr & (idx == `TMR_OFS_TL1);
    wire wr_th1 = wr & (idx == `TMR_OFS_TH1);
    wire wr_stat = wr & (idx == `TMR_OFS_IRQ_STAT);
    wire wr_mask = wr & (idx == `TMR_OFS_IRQ_MASK);

    // Overflow flags live in the control register; set beats any clear
    wire [1:0] ovf_clr = irq_ack_i | (wr_ctrl ? ~{dat_i[`TMR_BIT_OVF1], dat_i[`TMR_BIT_OVF0]} : 2'b00);
    wire flag0_next = ovf0 | (ctrl_reg[`TMR_BIT_OVF0] & ~ovf_clr[`TMR_BIT_ACK0]);
    wire flag1_next = ovf1 | (ctrl_reg[`TMR_BIT_OVF1] & ~ovf_clr[`TMR_BIT_ACK1]);
    wire [7:0] ctrl_next = {flag1_next, wr_ctrl ? dat_i[6] : ctrl_reg[6], flag0_next,
        wr_ctrl ? dat_i[4:0] : ctrl_reg[4:0]};
    wire [1:0] stat_next = {ovf1, ovf0} | (stat_reg & ~(wr_stat ? dat_i[1:0] : 2'b00));
    wire [1:0] mask_next = wr_mask ? dat_i[1:0] : mask_reg; // Lets the interrupt follow a mask write without lag

    // Mode and control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= `TMR_MODE_RESET;
            ctrl_reg <= `TMR_CTRL_RESET;
            stat_reg <= 2'b00;
            mask_reg <= 2'b00;
        end else begin
            if (wr_mode) begin
                mode_reg <= dat_i[7:0];
            end
            ctrl_reg <= ctrl_next;
            stat_reg <= stat_next;
            if (wr_mask) begin
                mask_reg <= dat_i[1:0];
            end
        end
    end

    // Timer 0 bytes; software writes take priority over counting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tl0_reg <= 8'h00;
            th0_reg <= 8'h00;
        end else begin
            if (wr_tl0) begin
                tl0_reg <= (mode0 == dual_timer_pkg::MODE_13BIT) ? {3'b000, dat_i[4:0]} : dat_i[7:0];
            end else if (inc0) begin
                tl0_reg <= nx0[7:0];
            end
            if (wr_th0) begin
                th0_reg <= dat_i[7:0];
            end else if (split0 ? inc0h : inc0) begin
                th0_reg <= split0 ? nx0h[7:0] : nx0[15:8];
            end
        end
    end

    // Timer 1 bytes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tl1_reg <= 8'h00;
            th1_reg <= 8'h00;
        end else begin
            if (wr_tl1) begin
                tl1_reg <= (mode1 == dual_timer_pkg::MODE_13BIT) ? {3'b000, dat_i[4:0]} : dat_i[7:0];
            end else if (inc1) begin
                tl1_reg <= nx1[7:0];
            end
            if (wr_th1) begin
                th1_reg <= dat_i[7:0];
            end else if (inc1) begin
                th1_reg <= nx1[15:8];
            end
        end
    end

    // Read mux; unmapped words read zero and are still acknowledged
    logic [7:0] rd_byte;
    always_comb begin
        unique case (idx)
            `TMR_OFS_MODE: rd_byte = mode_reg;
            `TMR_OFS_CTRL: rd_byte = ctrl_reg;
            `TMR_OFS_TL0: rd_byte = tl0_reg;
            `TMR_OFS_TH0: rd_byte = th0_reg;
            `TMR_OFS_TL1: rd_byte = tl1_reg;
            `TMR_OFS_TH1: rd_byte = th1_reg;
            `TMR_OFS_IRQ_STAT: rd_byte = {6'h00, stat_reg};
            `TMR_OFS_IRQ_MASK: rd_byte = {6'h00, mask_reg};
            default: rd_byte = 8'h00;
        endcase
    end

    // Single-wait-state answer: ack one cycle after the request, data registered with it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            irq_o <= 1'b0;
        end else begin
            ack_o <= req;
            dat_o <= req ? {24'h000000, rd_byte} : 32'h0000_0000;
            irq_o <= |(stat_next & mask_next);
        end
    end

    // Checks
    sequence s_mcycle_gap;
        !mcycle_reg [*8] ##1 !mcycle_reg [*3];
    endsequence
    property p_mcycle_spacing;
        @(posedge clk_i) disable iff (rst_i) mcycle_reg |=> s_mcycle_gap ##1 mcycle_reg;
    endproperty
    a_mcycle_spacing: assert property (p_mcycle_spacing) else $error("machine cycle not 12 clocks");

    property p_halt_holds;
        @(posedge clk_i) disable iff (rst_i)
            (!ctrl_reg[`TMR_BIT_RUN1] && !wr_tl1 && !wr_th1) |=> $stable(tl1_reg) && $stable(th1_reg);
    endproperty
    a_halt_holds: assert property (p_halt_holds) else $error("stopped timer 1 changed");

    property p_mode0_top_zero;
        @(posedge clk_i) disable iff (rst_i)
            ($past(inc0) && $past(mode_reg[1:0]) == 2'b00) |-> tl0_reg[7:5] == 3'b000;
    endproperty
    a_mode0_top_zero: assert property (p_mode0_top_zero) else $error("13-bit mode top bits set");

    property p_reload;
        @(posedge clk_i) disable iff (rst_i) (mode0 == dual_timer_pkg::MODE_RELOAD8 && inc0 && tl0_reg == 8'hFF && !wr_tl0)
            |=> tl0_reg == $past(th0_reg);
    endproperty
    a_reload: assert property (p_reload) else $error("auto-reload failed");

    property p_t1_split_stop;
        @(posedge clk_i) disable iff (rst_i) (mode1 == dual_timer_pkg::MODE_SPLIT && !wr_tl1) |=> $stable(tl1_reg);
    endproperty
    a_t1_split_stop: assert property (p_t1_split_stop) else $error("timer 1 ran in mode 3");

    property p_flag_set;
        @(posedge clk_i) disable iff (rst_i) ovf0 |=> ctrl_reg[`TMR_BIT_OVF0] && stat_reg[0];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("overflow flag not set");

    property p_gate_blocks;
        @(posedge clk_i) disable iff (rst_i) (mode_reg[`TMR_BIT_GATE0] && !gate0) |-> !inc0;
    endproperty
    a_gate_blocks: assert property (p_gate_blocks) else $error("gated timer counted");

    property p_split_high_flag;
        @(posedge clk_i) disable iff (rst_i) (split0 && inc0h && th0_reg == 8'hFF) |=> ctrl_reg[`TMR_BIT_OVF1];
    endproperty
    a_split_high_flag: assert property (p_split_high_flag) else $error("split high byte flag missing");

    property p_count_edge;
        @(posedge clk_i) disable iff (rst_i) (mode_reg[`TMR_BIT_CT0] && inc0) |-> fall0 && mcycle_reg;
    endproperty
    a_count_edge: assert property (p_count_edge) else $error("counter ticked without edge");
endmodule

/* File: dual_timer_counter_tb.sv */
// Self-checking bench for the dual timer/counter: register table, then timer, counter and flag cases.
// Assumes the pin model drives the count and gate pins; Wishbone master tasks live here.
`include "dual_timer_params.svh"
module dual_timer_counter_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [3:0] idx;
        logic [7:0] wd;
        logic [7:0] exp;
    } row_t;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [5:0] adr = 6'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h00000000;
    logic [1:0] irq_ack = 2'h0;
    logic [31:0] rdat;
    logic ack;
    logic irq;
    logic cnt0, cnt1, gate0, gate1;
    logic [7:0] v;
    int n_fail = 0;
    int checks_done = 0;
    // Write then read back; unmapped index, masked low byte, flags not settable by software
    row_t rows [9] = '{
        '{4'h8, 8'hFF, 8'h00}, '{4'h2, 8'hFF, 8'h1F}, '{4'h4, 8'hFF, 8'h1F},
        '{4'h3, 8'hA5, 8'hA5}, '{4'h5, 8'h5A, 8'h5A}, '{4'h1, 8'hAF, 8'h0F},
        '{4'h7, 8'h03, 8'h03}, '{4'h6, 8'hFF, 8'h00}, '{4'h0, 8'hA5, 8'hA5}
    };

    always #50 clk_i = ~clk_i;

    dual_timer_counter i_dual_timer_counter (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
        .count_input_zero_i(cnt0), .count_input_one_i(cnt1),
        .ext_irq_input_zero_i(gate0), .ext_irq_input_one_i(gate1),
        .irq_ack_i(irq_ack), .irq_o(irq)
    );

    dual_timer_pins_model i_dual_timer_pins_model (
        .clk_i(clk_i), .count_input_zero_o(cnt0), .count_input_one_o(cnt1),
        .ext_irq_input_zero_o(gate0), .ext_irq_input_one_o(gate1)
    );

    task automatic results();
        $display("Counts: %0d checks, %0d mismatches", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Exact match when lo equals hi, else an inclusive range
    task automatic chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        checks_done++;
        if ((got === lo) !== 1'b1 && ((got > lo) && (got <= hi)) !== 1'b1) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // Classic single cycle; request held until ack is sampled high
    task automatic wb(input logic [3:0] idx, input logic w, input logic [7:0] wd, output logic [7:0] rd);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= {idx, 2'b00};
        wdat <= {24'h000000, wd};
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (ack !== 1'b1) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, ack, 1'b1);
            results();
        end
        rd = rdat[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [7:0] unused;
        wb(idx, 1'b1, d, unused);
    endtask

    task automatic rc(input logic [3:0] idx, input logic [7:0] lo, input logic [7:0] hi);
        wb(idx, 1'b0, 8'h00, v);
        chk(v, lo, hi);
    endtask

    // Polls until all bits of m are set; bounded so a dead timer cannot hang the run
    task automatic wait_set(input logic [3:0] idx, input logic [7:0] m);
        int k;
        k = 0;
        do begin
            wb(idx, 1'b0, 8'h00, v);
            k++;
        end while ((v & m) !== m && k < 60);
        if ((v & m) !== m) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, v, m);
            results();
        end
    endtask

    task automatic ackp(input logic [1:0] b);
        @(posedge clk_i);
        irq_ack <= b;
        @(posedge clk_i);
        irq_ack <= 2'h0;
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rc(4'(i), 8'h00, 8'h00);
        end
        for (int i = 0; i < 9; i++) begin
            wr(rows[i].idx, rows[i].wd);
            rc(rows[i].idx, rows[i].exp, rows[i].exp);
        end
        $display("done: register table");
        // Reset in mid-run clears what the table left behind
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        rc(`TMR_OFS_MODE, 8'h00, 8'h00);
        rc(`TMR_OFS_CTRL, 8'h00, 8'h00);
        $display("done: reset");
        // 483 clocks between start and stop give 40 or 41 ticks
        wr(`TMR_OFS_MODE, 8'h01);
        wr(`TMR_OFS_CTRL, 8'h10);
        repeat (480) @(posedge clk_i);
        wr(`TMR_OFS_CTRL, 8'h00);
        rc(`TMR_OFS_TL0, 8'h28, 8'h29);
        repeat (60) @(posedge clk_i);
        rc(`TMR_OFS_TL0, v, v);
        $display("done: timer rate");
        // Mode 1 wrap, flag, interrupt, acknowledge
        wr(`TMR_OFS_TL0, 8'hFD);
        wr(`TMR_OFS_TH0, 8'hFF);
        wr(`TMR_OFS_IRQ_MASK, 8'h01);
        wr(`TMR_OFS_CTRL, 8'h10);
        wait_set(`TMR_OFS_CTRL, 8'h20);
        wr(`TMR_OFS_CTRL, 8'h20);
        chk({7'h00, irq}, 8'h01, 8'h01);
        rc(`TMR_OFS_TH0, 8'h00, 8'h00);
        rc(`TMR_OFS_TL0, 8'h00, 8'h01);
        rc(`TMR_OFS_CTRL, 8'h20, 8'h20);
        ackp(2'b01);
        rc(`TMR_OFS_CTRL, 8'h00, 8'h00);
        rc(`TMR_OFS_IRQ_STAT, 8'h01, 8'h01);
        wr(`TMR_OFS_IRQ_STAT, 8'h01);
        rc(`TMR_OFS_IRQ_STAT, 8'h00, 8'h00);
        chk({7'h00, irq}, 8'h00, 8'h00);
        $display("done: mode 1 overflow");
        // Mode 0 overflows at 13 bits
        wr(`TMR_OFS_MODE, 8'h00);
        wr(`TMR_OFS_TH0, 8'hFF);
        wr(`TMR_OFS_TL0, 8'h1E);
        wr(`TMR_OFS_CTRL, 8'h10);
        wait_set(`TMR_OFS_CTRL, 8'h20);
        wr(`TMR_OFS_CTRL, 8'h00);
        rc(`TMR_OFS_CTRL, 8'h00, 8'h00);
        rc(`TMR_OFS_TH0, 8'h00, 8'h00);
        rc(`TMR_OFS_TL0, 8'h00, 8'h01);
        wr(`TMR_OFS_IRQ_STAT, 8'h03);
        $display("done: mode 0 overflow");
        // Mode 2 on both timers; timer 1's interrupt stays masked
        wr(`TMR_OFS_MODE, 8'h22);
        wr(`TMR_OFS_TH1, 8'hF0);
        wr(`TMR_OFS_TL1, 8'hFE);
        wr(`TMR_OFS_TH0, 8'hE0);
        wr(`TMR_OFS_TL0, 8'hFE);
        wr(`TMR_OFS_CTRL, 8'h50);
        wait_set(`TMR_OFS_CTRL, 8'hA0);
        wr(`TMR_OFS_CTRL, 8'hA0);
        rc(`TMR_OFS_TL1, 8'hF0, 8'hF1);
        rc(`TMR_OFS_TH1, 8'hF0, 8'hF0);
        rc(`TMR_OFS_TL0, 8'hE0, 8'hE1);
        rc(`TMR_OFS_TH0, 8'hE0, 8'hE0);
        wr(`TMR_OFS_IRQ_STAT, 8'h01);
        rc(`TMR_OFS_IRQ_STAT, 8'h02, 8'h02);
        chk({7'h00, irq}, 8'h00, 8'h00);
        ackp(2'b10);
        rc(`TMR_OFS_CTRL, 8'h20, 8'h20);
        wr(`TMR_OFS_IRQ_STAT, 8'h02);
        $display("done: mode 2 reload");
        // Timer 0 split, timer 1 frozen in mode 3
        wr(`TMR_OFS_TL1, 8'h55);
        wr(`TMR_OFS_MODE, 8'h33);
        wr(`TMR_OFS_TL0, 8'hFE);
        wr(`TMR_OFS_TH0, 8'hFE);
        wr(`TMR_OFS_CTRL, 8'h50);
        wait_set(`TMR_OFS_CTRL, 8'hA0);
        wr(`TMR_OFS_CTRL, 8'h00);
        rc(`TMR_OFS_TL1, 8'h55, 8'h55);
        rc(`TMR_OFS_TL0, 8'h00, 8'h01);
        rc(`TMR_OFS_TH0, 8'h00, 8'h01);
        wr(`TMR_OFS_IRQ_STAT, 8'h03);
        $display("done: split mode");
        // Both counters on pins; gate closes timer 0 only
        wr(`TMR_OFS_MODE, 8'hDD);
        for (int i = 2; i < 6; i++) begin
            wr(4'(i), 8'h00);
        end
        wr(`TMR_OFS_CTRL, 8'h50);
        i_dual_timer_pins_model.set_gate(2'b11);
        repeat (24) @(posedge clk_i);
        i_dual_timer_pins_model.pulse(2'b11, 3);
        repeat (48) @(posedge clk_i);
        i_dual_timer_pins_model.set_gate(2'b10);
        repeat (24) @(posedge clk_i);
        i_dual_timer_pins_model.pulse(2'b11, 2);
        repeat (48) @(posedge clk_i);
        wr(`TMR_OFS_CTRL, 8'h00);
        rc(`TMR_OFS_TL0, 8'h03, 8'h03);
        rc(`TMR_OFS_TL1, 8'h05, 8'h05);
        $display("done: event counting");
        results();
    end
endmodule

/* File: dual_timer_params.svh */
// Constants for the dual timer/counter block: offsets, field positions, resets, timing.
// Assumes a Wishbone slave with 32-bit data, one register per aligned word.
`ifndef DUAL_TIMER_PARAMS_SVH
`define DUAL_TIMER_PARAMS_SVH
`define TMR_OFS_MODE 4'h0
`define TMR_OFS_CTRL 4'h1
`define TMR_OFS_TL0 4'h2
`define TMR_OFS_TH0 4'h3
`define TMR_OFS_TL1 4'h4
`define TMR_OFS_TH1 4'h5
`define TMR_OFS_IRQ_STAT 4'h6
`define TMR_OFS_IRQ_MASK 4'h7
`define TMR_MODE_RESET 8'h00
`define TMR_CTRL_RESET 8'h00
`define TMR_BIT_GATE1 7
`define TMR_BIT_CT1 6
`define TMR_BIT_MODE1_HI 5
`define TMR_BIT_MODE1_LO 4
`define TMR_BIT_GATE0 3
`define TMR_BIT_CT0 2
`define TMR_BIT_MODE0_HI 1
`define TMR_BIT_MODE0_LO 0
`define TMR_BIT_OVF1 7
`define TMR_BIT_RUN1 6
`define TMR_BIT_OVF0 5
`define TMR_BIT_RUN0 4
`define TMR_BIT_ACK1 1
`define TMR_BIT_ACK0 0
`define TMR_CLK_PER_MCYCLE 12
`endif

/* File: dual_timer_pins_model.sv */
// Pin model for the dual timer: drives both count pins and both gate pins.
// Assumes the bench calls its tasks; every pin change lands just after a rising clock edge.
module dual_timer_pins_model #(
    parameter int HOLD_CLKS = 36
) (
    input wire logic clk_i,
    output logic count_input_zero_o,
    output logic count_input_one_o,
    output logic ext_irq_input_zero_o,
    output logic ext_irq_input_one_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // Count pins idle high, so the first low is a clean falling edge
    initial begin
        count_input_zero_o = 1'b1;
        count_input_one_o = 1'b1;
        ext_irq_input_zero_o = 1'b0;
        ext_irq_input_one_o = 1'b0;
    end

    // Gate levels, bit 0 for timer 0 and bit 1 for timer 1
    task automatic set_gate(input logic [1:0] lvl);
        @(posedge clk_i);
        ext_irq_input_zero_o <= lvl[0];
        ext_irq_input_one_o <= lvl[1];
    endtask

    // Each level stands three machine cycles, so slow sampling cannot miss it
    task automatic pulse(input logic [1:0] pins, input int n);
        repeat (n) begin
            @(posedge clk_i);
            if (pins[0]) count_input_zero_o <= 1'b0;
            if (pins[1]) count_input_one_o <= 1'b0;
            repeat (HOLD_CLKS) @(posedge clk_i);
            count_input_zero_o <= 1'b1;
            count_input_one_o <= 1'b1;
            repeat (HOLD_CLKS) @(posedge clk_i);
        end
    endtask
endmodule

/* File: dual_timer_pkg.sv */
// Types shared by the dual timer/counter block.
// Assumes the constants header is included by the design files.
package dual_timer_pkg;
    typedef enum logic [1:0] {
        MODE_13BIT,
        MODE_16BIT,
        MODE_RELOAD8,
        MODE_SPLIT
    } timer_mode_t;
endpackage

/* File: timer_input_sampler.sv */
// Samples one external count pin and one gate pin, and detects falling edges per machine cycle.
// Assumes asynchronous pins; each passes two flip-flops before any logic reads it.
`include "dual_timer_params.svh"
module timer_input_sampler (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic mcycle_i,
    input wire logic count_pin_i,
    input wire logic gate_pin_i,
    output logic fall_o,
    output logic gate_o
);
    logic cnt_meta_reg;
    logic cnt_sync_reg;
    logic gate_meta_reg;
    logic gate_sync_reg;
    logic cnt_prev_reg;
    logic cnt_last_reg;

    // Two-stage synchronisers; first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_meta_reg <= 1'b0;
            cnt_sync_reg <= 1'b0;
            gate_meta_reg <= 1'b0;
            gate_sync_reg <= 1'b0;
        end else begin
            cnt_meta_reg <= count_pin_i;
            cnt_sync_reg <= cnt_meta_reg;
            gate_meta_reg <= gate_pin_i;
            gate_sync_reg <= gate_meta_reg;
        end
    end

    // Level sampled once per machine cycle; a fall needs two samples, hence two cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_prev_reg <= 1'b0;
            cnt_last_reg <= 1'b0;
        end else if (mcycle_i) begin
            cnt_last_reg <= cnt_sync_reg;
            cnt_prev_reg <= cnt_last_reg;
        end
    end

    // One pulse at the sampling strobe after a 1-to-0 is seen
    assign fall_o = mcycle_i & cnt_prev_reg & ~cnt_last_reg;
    assign gate_o = gate_sync_reg;
endmodule
